/* File: verilog/eepac_top.sv */
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "eepac_defines.svh"

module eepac_top (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  input  wire logic [3:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output var  logic                 s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output var  logic                 s_axi_wready,
  output var  logic [1:0]           s_axi_bresp,
  output var  logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [3:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output var  logic                 s_axi_arready,
  output var  logic [31:0]          s_axi_rdata,
  output var  logic [1:0]           s_axi_rresp,
  output var  logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output var  eepac_pkg::eepac_ctrl_t ctrl_status
);
  import eepac_pkg::*;

  // Per-byte result of a program operation
  function automatic logic [7:0] prog_byte(input eepac_mode_t m,
                                           input logic [7:0] old_b,
                                           input logic [7:0] new_b);
    case (m)
      PM_ERASE_WRITE: prog_byte = new_b;
      PM_ERASE_ONLY:  prog_byte = 8'hFF;
      PM_WRITE_ONLY:  prog_byte = old_b & new_b;
      default:        prog_byte = old_b;
    endcase
  endfunction : prog_byte

  // Mode field of a written control byte
  function automatic eepac_mode_t mode_of(input logic [7:0] b);
    mode_of = eepac_mode_t'(b[`EEPAC_BIT_PM1:`EEPAC_BIT_PM0]);
  endfunction : mode_of

  // Page slot picked by the low address bits
  function automatic logic [`EEPAC_PAGE_BITS-1:0] slot_of(input logic [8:0] ad);
    slot_of = ad[`EEPAC_PAGE_BITS-1:0];
  endfunction : slot_of

  // Array index of one slot inside the page of an address
  function automatic logic [8:0] page_idx(input logic [8:0] ad, input int unsigned s);
    page_idx = {ad[8:`EEPAC_PAGE_BITS], 3'(s)};
  endfunction : page_idx

  logic [7:0]   mem [0:`EEPAC_LAST];
  logic [7:0]   pbuf [0:`EEPAC_PAGE_LEN-1];
  logic [`EEPAC_PAGE_LEN-1:0] pvld_q;

  logic         aw_held_q;
  logic         w_held_q;
  logic [3:0]   waddr_q;
  logic [31:0]  wdata_q;
  logic [3:0]   wstrb_q;
  logic         wr_fire;
  logic         wr_ok;
  logic         rd_ok;

  logic [8:0]   addr_q;
  logic [7:0]   data_q;
  eepac_ctrl_t  ctrl_q;
  eepac_state_t state_q;
  logic [2:0]   mwe_cnt_q;
  logic [5:0]   prog_cnt_q;
  logic [8:0]   op_addr_q;
  eepac_mode_t  op_mode_q;
  logic         op_page_q;
  logic [7:0]   op_data_q;

  logic         wr_addr_low;
  logic         wr_addr_high;
  logic         wr_data;
  logic         wr_ctrl;
  logic         start_op;
  logic         prog_done;
  logic [7:0]   wbyte;
  logic         idle;
  logic         buf_wr;
  logic         rd_strobe;
  logic         mwe_arm;
  logic         flush_op;
  eepac_mode_t  wmode;

  // Write decode
  assign wr_fire      = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign wr_ok        = wr_fire & wstrb_q[0];
  assign wbyte        = wdata_q[7:0];
  assign wr_addr_low  = wr_ok & (waddr_q == `EEPAC_OFS_ADDR_LOW);
  assign wr_addr_high = wr_ok & (waddr_q == `EEPAC_OFS_ADDR_HIGH);
  assign wr_data      = wr_ok & (waddr_q == `EEPAC_OFS_DATA);
  assign wr_ctrl      = wr_ok & (waddr_q == `EEPAC_OFS_CTRL);
  assign idle         = (state_q == ST_IDLE);
  assign wmode        = mode_of(wbyte);
  assign start_op     = wr_ctrl & wbyte[`EEPAC_BIT_PE] & ctrl_q.mwe & idle;

  // Strobes decoded from control and data writes, the program counter and the read address
  assign flush_op     = start_op & (wmode == PM_FLUSH);
  assign mwe_arm      = wr_ctrl & wbyte[`EEPAC_BIT_MWE] & ~wbyte[`EEPAC_BIT_PE];
  assign rd_strobe    = wr_ctrl & wbyte[`EEPAC_BIT_RE] & idle;
  assign buf_wr       = wr_data & ctrl_q.page & idle;
  assign prog_done    = (state_q == ST_PROG) & (prog_cnt_q == 6'd1);
  assign rd_ok        = (s_axi_araddr[1:0] == 2'b00);

  // Write address and data channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      waddr_q       <= 4'h0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else if (ce) begin
      s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_q <= 1'b1;
        waddr_q   <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response, after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `EEPAC_RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (waddr_q[1:0] == 2'b00) ? `EEPAC_RESP_OKAY : `EEPAC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel with registered data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `EEPAC_RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rd_ok ? `EEPAC_RESP_OKAY : `EEPAC_RESP_SLVERR;
        case (s_axi_araddr)
          `EEPAC_OFS_ADDR_LOW:  s_axi_rdata <= {24'h00_0000, addr_q[7:0]};
          `EEPAC_OFS_ADDR_HIGH: s_axi_rdata <= {24'h00_0000, 7'h00, addr_q[8]};
          `EEPAC_OFS_DATA:      s_axi_rdata <= {24'h00_0000, data_q};
          `EEPAC_OFS_CTRL:      s_axi_rdata <= {24'h00_0000, ctrl_q};
          default:              s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Nine-bit address, upper high-byte bits dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_q <= `EEPAC_RST_ADDR;
    end else if (ce) begin
      if (wr_addr_low) begin
        addr_q[7:0] <= wbyte;
      end else if (wr_addr_high) begin
        addr_q[8] <= wbyte[0];
      end
    end
  end

  // Data byte: software writes and array reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_q <= `EEPAC_RST_BYTE;
    end else if (ce) begin
      if (wr_data) begin
        data_q <= wbyte;
      end else if (rd_strobe) begin
        data_q <= mem[addr_q];
      end
    end
  end

  // Page buffer valid flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pvld_q <= '0;
    end else if (ce) begin
      if (prog_done | flush_op) begin
        pvld_q <= '0;
      end else if (buf_wr) begin
        pvld_q[slot_of(addr_q)] <= 1'b1;
      end
    end
  end

  // Page buffer contents
  always_ff @(posedge aclk) begin
    if (ce & buf_wr) begin
      pbuf[slot_of(addr_q)] <= wbyte;
    end
  end

  // Array update at the end of a program operation
  always_ff @(posedge aclk) begin
    if (ce & prog_done) begin
      if (op_page_q) begin
        for (int i = 0; i < `EEPAC_PAGE_LEN; i++) begin
          if (pvld_q[i]) begin
            mem[page_idx(op_addr_q, i)] <=
              prog_byte(op_mode_q, mem[page_idx(op_addr_q, i)], pbuf[i]);
          end
        end
      end else begin
        mem[op_addr_q] <= prog_byte(op_mode_q, mem[op_addr_q], op_data_q);
      end
    end
  end

  // Master enable window counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mwe_cnt_q <= 3'd0;
    end else if (ce) begin
      if (mwe_arm) begin
        mwe_cnt_q <= 3'(`EEPAC_MWE_CYCLES);
      end else if (start_op) begin
        mwe_cnt_q <= 3'd0;
      end else if (mwe_cnt_q != 3'd0) begin
        mwe_cnt_q <= mwe_cnt_q - 3'd1;
      end
    end
  end

  // Control register and program sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= '0;
      state_q    <= ST_IDLE;
      prog_cnt_q <= 6'd0;
      op_addr_q  <= `EEPAC_RST_ADDR;
      op_mode_q  <= PM_ERASE_WRITE;
      op_page_q  <= 1'b0;
      op_data_q  <= `EEPAC_RST_BYTE;
    end else if (ce) begin
      ctrl_q.re <= 1'b0;
      if (mwe_cnt_q == 3'd1) begin
        ctrl_q.mwe <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_q.irq_en <= wbyte[`EEPAC_BIT_IRQEN];
        if (!ctrl_q.pe) begin
          ctrl_q.mode <= wmode;
          ctrl_q.page <= wbyte[`EEPAC_BIT_PAGE] | ctrl_q.page;
        end
        if (mwe_arm) begin
          ctrl_q.mwe <= 1'b1;
        end
      end
      case (state_q)
        ST_IDLE: begin
          if (start_op) begin
            ctrl_q.mwe <= 1'b0;
            if (flush_op) begin
              ctrl_q.page <= 1'b0;
            end else begin
              ctrl_q.pe   <= 1'b1;
              ctrl_q.busy <= 1'b1;
              ctrl_q.mode <= wmode;
              state_q     <= ST_PROG;
              prog_cnt_q  <= 6'(`EEPAC_PROG_CYCLES);
              op_addr_q   <= addr_q;
              op_mode_q   <= wmode;
              op_page_q   <= ctrl_q.page;
              op_data_q   <= data_q;
            end
          end
        end
        ST_PROG: begin
          prog_cnt_q <= prog_cnt_q - 6'd1;
          if (prog_done) begin
            ctrl_q.busy <= 1'b0;
            ctrl_q.pe   <= 1'b0;
            ctrl_q.page <= 1'b0;
            state_q     <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Status image out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_status <= '0;
    end else if (ce) begin
      ctrl_status <= ctrl_q;
    end
  end

endmodule : eepac_top

`default_nettype wire

/* File: verilog/eepac_defines.svh */
`ifndef EEPAC_DEFINES_SVH
`define EEPAC_DEFINES_SVH

// Register byte offsets on the AXI4-Lite bus
`define EEPAC_OFS_ADDR_LOW  4'h0
`define EEPAC_OFS_ADDR_HIGH 4'h4
`define EEPAC_OFS_DATA      4'h8
`define EEPAC_OFS_CTRL      4'hC

// Control register field positions
`define EEPAC_BIT_BUSY  7
`define EEPAC_BIT_PAGE  6
`define EEPAC_BIT_PM1   5
`define EEPAC_BIT_PM0   4
`define EEPAC_BIT_IRQEN 3
`define EEPAC_BIT_MWE   2
`define EEPAC_BIT_PE    1
`define EEPAC_BIT_RE    0

// Reset values
`define EEPAC_RST_BYTE 8'h00
`define EEPAC_RST_ADDR 9'h000

// Array geometry
`define EEPAC_DEPTH     512
`define EEPAC_LAST      511
`define EEPAC_PAGE_BITS 3
`define EEPAC_PAGE_LEN  8

// Timing: master enable window and programming time
`define EEPAC_MWE_CYCLES   4
`define EEPAC_CLK_MHZ      40
`define EEPAC_PROG_TIME_NS 1000
`define EEPAC_PROG_CYCLES  ((`EEPAC_PROG_TIME_NS * `EEPAC_CLK_MHZ + 999) / 1000)

// AXI responses
`define EEPAC_RESP_OKAY   2'b00
`define EEPAC_RESP_SLVERR 2'b10

`endif

/* File: verilog/eepac_pkg.sv */
`default_nettype none

package eepac_pkg;

  // Programming mode field
  typedef enum logic [1:0] {
    PM_ERASE_WRITE = 2'b00,
    PM_ERASE_ONLY  = 2'b01,
    PM_WRITE_ONLY  = 2'b10,
    PM_FLUSH       = 2'b11
  } eepac_mode_t;

  // Sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_PROG = 1'b1
  } eepac_state_t;

  // Control register image, bit 7 down to bit 0
  typedef struct packed {
    logic        busy;
    logic        page;
    eepac_mode_t mode;
    logic        irq_en;
    logic        mwe;
    logic        pe;
    logic        re;
  } eepac_ctrl_t;

endpackage : eepac_pkg

`default_nettype wire

/* File: testbench/eepac_sva.sv */
`timescale 1ns/10ps
`default_nettype none

module eepac_sva (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic                   ce,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic [3:0]             s_axi_araddr,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic                   s_axi_rvalid,
  input wire logic [31:0]            s_axi_rdata,
  input wire eepac_pkg::eepac_ctrl_t ctrl_status
);
  import eepac_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  property p_rd_high;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h4 |=>
      s_axi_rvalid && s_axi_rdata[31:1] == 31'h0;
  endproperty
  a_rd_high: assert property (p_rd_high) else $error("address high spare bits");

  property p_busy_hold;
    $rose(ctrl_status.busy) |-> ctrl_status.busy [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  property p_busy_end;
    $rose(ctrl_status.busy) |-> ##[36:44] !ctrl_status.busy;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy never ended");

  property p_mwe_clear;
    $rose(ctrl_status.mwe) |-> ##[3:5] !ctrl_status.mwe;
  endproperty
  a_mwe_clear: assert property (p_mwe_clear) else $error("enable not cleared");

  property p_page_clear;
    $fell(ctrl_status.busy) |-> !ctrl_status.page;
  endproperty
  a_page_clear: assert property (p_page_clear) else $error("page kept after program");

  property p_page_frozen;
    ctrl_status.pe ##1 ctrl_status.pe |-> $stable(ctrl_status.page);
  endproperty
  a_page_frozen: assert property (p_page_frozen) else $error("page moved under strobe");

  property p_w_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_w_resp: assert property (p_w_resp) else $error("write response late");

  property p_r_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_resp: assert property (p_r_resp) else $error("read response late");
endmodule : eepac_sva

bind eepac_top eepac_sva u_sva (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .ctrl_status);

`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "eepac_defines.svh"

module tb;
  import eepac_pkg::*;
  logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, lfsr_q;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [8:0]  a;
  logic [7:0]  v, old;
  logic [1:0]  ms [4] = '{2'b00, 2'b10, 2'b01, 2'b00};
  eepac_ctrl_t ctrl_status;
  int          bad_count, checks, cyc;

  eepac_top DUT (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ctrl_status);

  // Clock, 25 ns period
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  // Array byte after programming in a given mode
  function automatic logic [7:0] pexp(input logic [1:0] m, input logic [7:0] o,
                                      input logic [7:0] n);
    case (m)
      2'b00: return n;
      2'b01: return 8'hFF;
      default: return o & n;
    endcase
  endfunction : pexp

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  // Write: both channels offered, each dropped when taken
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= ad;
    s_axi_wdata <= 32'(d);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (s_axi_awready) aw = 1'b0;
      if (s_axi_wready) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask : wr

  task automatic rdr(input logic [3:0] ad);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : rdr

  task automatic setad(input logic [8:0] x);
    wr(`EEPAC_OFS_ADDR_LOW, x[7:0]);
    wr(`EEPAC_OFS_ADDR_HIGH, {7'h00, x[8]});
  endtask : setad

  // Enable, then strobe with the mode at once
  task automatic prog(input logic [1:0] m);
    wr(`EEPAC_OFS_CTRL, 8'h04);
    wr(`EEPAC_OFS_CTRL, {2'b00, m, 4'h2});
  endtask : prog

  task automatic rdarr(input logic [8:0] x, input logic [7:0] e);
    setad(x);
    wr(`EEPAC_OFS_DATA, ~e);
    wr(`EEPAC_OFS_CTRL, 8'h01);
    rdr(`EEPAC_OFS_DATA);
    chk("array byte", 32'(e), rd);
  endtask : rdarr

  // Bench timeout
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, cyc, bad_count, checks} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {ce, s_axi_bready, s_axi_rready, s_axi_wstrb} = {3'b111, 4'h1};
    lfsr_q = 32'h0000_025c;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(`EEPAC_OFS_DATA);
    chk("data reset", 32'h0000_0000, rd);
    chk("read resp", 32'(`EEPAC_RESP_OKAY), 32'(rsp));
    wr(`EEPAC_OFS_ADDR_HIGH, 8'hFF);
    rdr(`EEPAC_OFS_ADDR_HIGH);
    chk("address high", 32'h0000_0001, rd);
    wr(4'h2, 8'h55);
    chk("misaligned resp", 32'(`EEPAC_RESP_SLVERR), 32'(rsp));
    rdr(4'h6);
    chk("misaligned read resp", 32'(`EEPAC_RESP_SLVERR), 32'(rsp));
    chk("misaligned read data", 32'h0000_0000, rd);
    for (int i = 0; i < 4; i++) begin
      lfsr_q = nxt(lfsr_q);
      a = lfsr_q[8:0];
      setad(a);
      rdr(`EEPAC_OFS_ADDR_LOW);
      chk("address low", 32'(a[7:0]), rd);
      rdr(`EEPAC_OFS_ADDR_HIGH);
      chk("address bit 8", 32'(a[8]), rd);
    end
    $display("address test done");
    for (int i = 0; i < 4; i++) begin
      lfsr_q = nxt(lfsr_q);
      v = lfsr_q[15:8];
      setad(a);
      wr(`EEPAC_OFS_DATA, v);
      prog(ms[i]);
      wr(`EEPAC_OFS_CTRL, 8'h40);
      rdr(`EEPAC_OFS_CTRL);
      chk("busy while programming", 32'h0000_0001, 32'(rd[7]));
      chk("page under strobe", 32'h0000_0000, 32'(rd[6]));
      chk("status mode", 32'(ms[i]), 32'(ctrl_status.mode));
      if (i == 0) begin
        ce <= 1'b0;
        repeat (60) @(posedge aclk);
        ce <= 1'b1;
        rdr(`EEPAC_OFS_CTRL);
        chk("busy held while frozen", 32'h0000_0001, 32'(rd[7]));
        chk("status busy", 32'h0000_0001, 32'(ctrl_status.busy));
      end
      do rdr(`EEPAC_OFS_CTRL); while (rd[7]);
      old = pexp(ms[i], old, v);
      rdarr(a, old);
    end
    wr(`EEPAC_OFS_CTRL, 8'h04);
    repeat (8) @(posedge aclk);
    wr(`EEPAC_OFS_CTRL, 8'h02);
    rdr(`EEPAC_OFS_CTRL);
    chk("late strobe busy", 32'h0000_0000, 32'(rd[7]));
    $display("byte program test done");
    wr(`EEPAC_OFS_CTRL, 8'h40);
    rdr(`EEPAC_OFS_CTRL);
    chk("page set", 32'h0000_0001, 32'(rd[6]));
    for (int k = 0; k < 8; k += 7) begin
      wr(`EEPAC_OFS_ADDR_LOW, {a[7:3], 3'(k)});
      wr(`EEPAC_OFS_DATA, v + 8'(k));
    end
    setad({a[8:3], 3'h0});
    prog(2'b00);
    do rdr(`EEPAC_OFS_CTRL); while (rd[7]);
    chk("page after program", 32'h0000_0000, 32'(rd[6]));
    rdarr({a[8:3], 3'h0}, v);
    rdarr({a[8:3], 3'h7}, v + 8'h07);
    $display("page test done");
    wr(`EEPAC_OFS_CTRL, 8'h40);
    wr(`EEPAC_OFS_ADDR_LOW, {a[7:3], 3'h0});
    wr(`EEPAC_OFS_DATA, 8'h00);
    prog(2'b01);
    do rdr(`EEPAC_OFS_CTRL); while (rd[7]);
    rdarr({a[8:3], 3'h7}, v + 8'h07);
    rdarr({a[8:3], 3'h0}, 8'hFF);
    $display("page erase test done");
    wr(`EEPAC_OFS_CTRL, 8'h40);
    wr(`EEPAC_OFS_ADDR_LOW, {a[7:3], 3'h0});
    wr(`EEPAC_OFS_DATA, ~v);
    prog(2'b11);
    rdr(`EEPAC_OFS_CTRL);
    chk("flush busy and page", 32'h0000_0000, 32'(rd[7:6]));
    rdarr({a[8:3], 3'h0}, 8'hFF);
    $display("flush test done");
    complete_run();
  end
endmodule : tb

`default_nettype wire
